// file: aqc_pkg.sv
// Shared constants, types and helpers for the queue 2 control block
package aqc_pkg;
  localparam int ADDR_W = 24;            // Byte address width of the register bus
  localparam int DATA_W = 32;            // Register bus data width
  // Register byte addresses
  localparam logic [23:0] STATUS0_ADDR = 24'h304810;
  localparam logic [23:0] MODE2_ADDR = 24'h304814;
  localparam logic [23:0] IRQ_STAT_ADDR = 24'h304818;
  localparam logic [23:0] IRQ_MASK_ADDR = 24'h30481c;
  // Mode control field positions (bit 0 of the map is the MSB, data bit 15)
  localparam int B_CIE = 15;
  localparam int B_PIE = 14;
  localparam int B_SSE = 13;
  localparam int MQ_HI = 12;
  localparam int MQ_LO = 8;
  localparam int B_RESUME = 7;
  localparam int BQ_HI = 6;
  localparam int BQ_LO = 0;
  // Status field positions
  localparam int FL_HI = 15;             // Six clearable flags sit in 15:10
  localparam int FL_LO = 10;
  localparam int QS_HI = 9;
  localparam int QS_LO = 6;
  localparam int CWP_HI = 5;
  localparam int CWP_LO = 0;
  // Index of each flag inside the six-bit flag vector
  localparam int F_Q2_OVR = 0;
  localparam int F_Q1_OVR = 1;
  localparam int F_Q2_PAUSE = 2;
  localparam int F_Q2_DONE = 3;
  localparam int F_Q1_PAUSE = 4;
  localparam int F_Q1_DONE = 5;
  // Interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int I_DONE = 0;
  localparam int I_PAUSE = 1;
  localparam int I_OVR = 2;
  // Widths and fixed values
  localparam int CWP_W = 6;
  localparam int BQ_W = 7;
  localparam int TMR_W = 17;
  localparam logic [5:0] LAST_CCW = 6'h3f;
  localparam logic [4:0] MODE_OFF = 5'h00;
  localparam logic [4:0] MODE_RSV_A = 5'h0f;
  localparam logic [4:0] MODE_RSV_B = 5'h10;
  localparam logic [4:0] MODE_RSV_C = 5'h1f;
  localparam logic [3:0] SW_CODE = 4'h1;
  localparam logic [3:0] RISE_CODE = 4'h2;
  localparam logic [3:0] FALL_CODE = 4'h3;
  localparam logic [3:0] TMR_CODE_LO = 4'h4;
  localparam logic [3:0] TMR_CODE_HI = 4'he;
  localparam logic [4:0] TMR_EXP_OFS = 5'h03;  // Code 4 gives exponent 7
  localparam int B_CONT = 4;             // Mode bit that selects continuous scan
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] QS_IDLE = 2'h0;
  localparam logic [1:0] QS_PAUSED = 2'h1;
  localparam logic [1:0] QS_ACTIVE = 2'h2;  // Also reads as suspended when queue 1 runs
  localparam logic [1:0] QS_PEND = 2'h3;

  // Queue 2 sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PEND = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_PAUSED = 5'h08,
    ST_SUSP = 5'h10
  } aqc_state_t;

  // Software triggered modes
  function automatic logic mode_is_sw(input logic [4:0] m);
    return m[3:0] == SW_CODE;
  endfunction
  // External edge modes
  function automatic logic mode_is_ext(input logic [4:0] m);
    return (m[3:0] == RISE_CODE) || (m[3:0] == FALL_CODE);
  endfunction
  // Interval or periodic timer modes
  function automatic logic mode_is_tmr(input logic [4:0] m);
    return (m[3:0] >= TMR_CODE_LO) && (m[3:0] <= TMR_CODE_HI);
  endfunction
  // Modes that never run: disabled and reserved codes
  function automatic logic mode_is_off(input logic [4:0] m);
    return (m == MODE_OFF) || (m == MODE_RSV_A) || (m == MODE_RSV_B) || (m == MODE_RSV_C);
  endfunction
  // Byte lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction
endpackage

// file: aqc_trig_if.sv
// Trigger request path between the sequencer and the trigger generator
`timescale 1ns/1ps
interface aqc_trig_if;
  logic [4:0] mode;     // Current operating mode
  logic conv_tick;      // One pulse per conversion clock period
  logic ext_trig;       // External trigger level
  logic restart;        // Reload the interval timer
  logic trig;           // Trigger event, one-cycle pulse
  modport ctrl (output mode, output conv_tick, output ext_trig, output restart, input trig);
  modport gen (input mode, input conv_tick, input ext_trig, input restart, output trig);
endinterface

// file: aqc_trig_gen.sv
// Edge and interval-timer trigger generator for queue 2
`timescale 1ns/1ps
module aqc_trig_gen
  import aqc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  aqc_trig_if.gen tif
);
  logic ext_prev_r;            // Last sampled external level
  logic [TMR_W-1:0] tmr_r;     // Conversion clock periods counted
  logic [TMR_W-1:0] tmr_nxt;
  logic [4:0] exp_w;           // Power of two for the timer modes
  logic [TMR_W-1:0] limit_w;   // Terminal count of the timer
  logic rise_w;
  logic fall_w;
  logic tmr_hit_w;

  // Exponent runs 7 to 17 across the timer codes
  assign exp_w = 5'({1'b0, tif.mode[3:0]} + TMR_EXP_OFS);
  assign limit_w = TMR_W'((33'h1 << exp_w) - 33'h1);
  assign rise_w = tif.ext_trig & ~ext_prev_r;
  assign fall_w = ~tif.ext_trig & ext_prev_r;
  assign tmr_hit_w = mode_is_tmr(tif.mode) && tif.conv_tick && (tmr_r == limit_w);
  // Edge polarity picked by the low mode bit
  assign tif.trig = (mode_is_ext(tif.mode) && (tif.mode[0] ? fall_w : rise_w))
                    || tmr_hit_w;

  // Timer advances once per conversion clock and wraps at the interval
  always_comb begin
    tmr_nxt = tmr_r;
    if (tif.restart || !mode_is_tmr(tif.mode)) begin
      tmr_nxt = '0;
    end else if (tif.conv_tick) begin
      tmr_nxt = tmr_hit_w ? '0 : TMR_W'(tmr_r + 17'h1);
    end
  end

  // Timer and edge history
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tmr_r <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      tmr_r <= tmr_nxt;
      ext_prev_r <= tif.ext_trig;
    end
  end
endmodule

// file: aqc_q2_ctrl.sv
// Queue 2 mode control, status flags and register slave of the converter
//
// Contract
// - Done interrupt only when done enable set; O_IRQ ignores the enable and is gated by imask_r only
// - Pause interrupt only when pause enable set; O_IRQ ignores the enable and is gated by imask_r only
// - Arm bit lets trigger start one scan
// - Arm bit writable, always reads zero
// - Arm bit self-clears after single scan ends
// - Mode field selects behaviour; zero disables
// - Codes 01, 11 are software scans via arm
// - Edge codes start scans on chosen edge
// - Interval timer single scans, 2^7 to 2^17
// - Periodic timer continuous scans, 2^7 to 2^17
// - Resume bit picks restart point after suspend
// - Resume change waits for end or mode change
// - Start index begins queue 2, ends queue 1
// - Start index 64 up gives queue 1 all
// - Flags clear by zero write after read
// - Other status fields are read-only
// - Done and pause flags set after store
// - Overrun on stray trigger, not software modes
`timescale 1ns/1ps
module aqc_q2_ctrl
  import aqc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [DATA_W-1:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [DATA_W-1:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic I_CONV_TICK,
  input wire logic I_EXT_TRIG,
  input wire logic I_CONV_DONE,
  input wire logic I_CCW_PAUSE,
  input wire logic I_CCW_EOQ,
  input wire logic I_Q1_ACTIVE,
  input wire logic [1:0] I_Q1_STATE,
  input wire logic [CWP_W-1:0] I_Q1_CWP,
  input wire logic I_Q1_DONE,
  input wire logic I_Q1_PAUSE,
  input wire logic I_Q1_OVERRUN,
  output logic O_CONV_REQ,
  output logic [CWP_W-1:0] O_CONV_INDEX,
  output logic [BQ_W-1:0] O_Q1_END_INDEX,
  output logic O_Q2_IRQ_REQ,
  output logic O_IRQ
);
  // Mode control register fields
  logic done_ie_r;                 // q2_done_irq_enable
  logic pause_ie_r;                // q2_pause_irq_enable
  logic arm_r;                     // q2_single_scan_arm, never read back
  logic [4:0] mode_r;              // q2_operating_mode
  logic resume_r;                  // Resume select as written
  logic resume_eff_r;              // Resume select in force
  logic [BQ_W-1:0] start_r;        // q2_start_index
  // Status and interrupt state
  logic [5:0] flag_r;              // Clearable flags, bit order of status 15:10
  logic [5:0] seen_r;              // Flags read as one since last clear
  logic [IRQ_W-1:0] ist_r;         // Sticky interrupt status
  logic [IRQ_W-1:0] imask_r;       // Interrupt mask
  // Sequencer
  aqc_state_t state_r;
  aqc_state_t state_nxt;
  logic [CWP_W-1:0] cwp_r;         // Command word in work
  logic [CWP_W-1:0] cwp_nxt;
  logic [CWP_W-1:0] subq_r;        // First word of the current sub-queue
  logic [CWP_W-1:0] subq_nxt;
  // Bus slave holding registers
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;

  aqc_trig_if tif();

  aqc_trig_gen u_trig (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .tif(tif)
  );

  // Write path decode
  wire wr_fire = aw_full_r && w_full_r && !bvalid_r;
  wire wr_stat = wr_fire && (awaddr_r == STATUS0_ADDR);
  wire wr_mode = wr_fire && (awaddr_r == MODE2_ADDR);
  wire wr_ist = wr_fire && (awaddr_r == IRQ_STAT_ADDR);
  wire wr_imask = wr_fire && (awaddr_r == IRQ_MASK_ADDR);
  wire wr_hit = wr_stat || wr_mode || wr_ist || wr_imask;
  // Read path decode
  wire rd_fire = I_AXI_ARVALID && !rvalid_r;
  wire rd_stat = I_AXI_ARADDR == STATUS0_ADDR;
  wire rd_mode = I_AXI_ARADDR == MODE2_ADDR;
  wire rd_ist = I_AXI_ARADDR == IRQ_STAT_ADDR;
  wire rd_imask = I_AXI_ARADDR == IRQ_MASK_ADDR;
  wire rd_hit = rd_stat || rd_mode || rd_ist || rd_imask;

  // New mode control word as merged from the byte lanes
  wire [15:0] mode_old = {done_ie_r, pause_ie_r, arm_r, mode_r, resume_r, start_r};
  wire [15:0] mode_new = merge16(mode_old, wdata_r, wstrb_r);
  wire mode_chg = wr_mode && (mode_new[MQ_HI:MQ_LO] != mode_r);
  wire sse_go = wr_mode && mode_new[B_SSE];

  // Queue 2 owns no words once its start is past the table
  wire q2_empty = start_r[BQ_W-1];
  wire q2_off = mode_is_off(mode_r) || q2_empty;
  wire is_sw = mode_is_sw(mode_r);
  wire is_cont = mode_r[B_CONT];
  wire [CWP_W-1:0] first_ccw = start_r[CWP_W-1:0];
  // Start event: arm write for software modes, trigger pulse otherwise
  wire go_evt = is_sw ? sse_go : tif.trig;
  // A word finishes while running; last word ends the queue
  wire word_done = (state_r == ST_ACTIVE) && I_CONV_DONE;
  wire at_end = word_done && (I_CCW_EOQ || (cwp_r == LAST_CCW));
  wire at_pause = word_done && I_CCW_PAUSE && !at_end;
  // Stray trigger while the queue is busy or waiting to resume
  wire q2_ovr = tif.trig && !is_sw && !q2_off
                && ((state_r == ST_ACTIVE) || (state_r == ST_SUSP));

  assign tif.mode = mode_r;
  assign tif.conv_tick = I_CONV_TICK;
  assign tif.ext_trig = I_EXT_TRIG;
  // Timer interval starts afresh on every mode change and while idle
  assign tif.restart = mode_chg || (state_r == ST_IDLE);

  // Sequencer next-state logic
  always_comb begin
    state_nxt = state_r;
    cwp_nxt = cwp_r;
    subq_nxt = subq_r;
    case (state_r)
      ST_IDLE: begin
        cwp_nxt = first_ccw;
        subq_nxt = first_ccw;
        if (!q2_off) begin
          if (is_sw && arm_r) begin
            state_nxt = ST_ACTIVE;
          end else if (!is_sw && (arm_r || is_cont)) begin
            state_nxt = ST_PEND;
          end
        end
      end
      ST_PEND: begin
        if (tif.trig) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (at_end) begin
          cwp_nxt = first_ccw;
          subq_nxt = first_ccw;
          // Continuous scans go round again, single scans stop
          if (!is_cont) begin
            state_nxt = ST_IDLE;
          end else if (is_sw) begin
            state_nxt = ST_ACTIVE;
          end else begin
            state_nxt = ST_PEND;
          end
        end else if (at_pause) begin
          cwp_nxt = CWP_W'(cwp_r + 6'h1);
          subq_nxt = CWP_W'(cwp_r + 6'h1);
          state_nxt = ST_PAUSED;
        end else if (word_done) begin
          cwp_nxt = CWP_W'(cwp_r + 6'h1);
        end else if (I_Q1_ACTIVE) begin
          state_nxt = ST_SUSP;
        end
      end
      ST_PAUSED: begin
        if (go_evt) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_SUSP: begin
        if (!I_Q1_ACTIVE) begin
          state_nxt = ST_ACTIVE;
          cwp_nxt = resume_eff_r ? cwp_r : subq_r;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Disabling the queue or changing its operating mode drops any scan in progress
    if (mode_chg || q2_off) begin
      state_nxt = ST_IDLE;
      cwp_nxt = first_ccw;
      subq_nxt = first_ccw;
    end
  end

  // Sequencer registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state_r <= ST_IDLE;
      cwp_r <= '0;
      subq_r <= '0;
    end else begin
      state_r <= state_nxt;
      cwp_r <= cwp_nxt;
      subq_r <= subq_nxt;
    end
  end

  // Mode control register; arm clears itself when its single scan ends
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      done_ie_r <= 1'b0;
      pause_ie_r <= 1'b0;
      arm_r <= 1'b0;
      mode_r <= MODE_OFF;
      resume_r <= 1'b0;
      start_r <= '0;
    end else if (wr_mode) begin
      done_ie_r <= mode_new[B_CIE];
      pause_ie_r <= mode_new[B_PIE];
      arm_r <= mode_new[B_SSE];
      mode_r <= mode_new[MQ_HI:MQ_LO];
      resume_r <= mode_new[B_RESUME];
      start_r <= mode_new[BQ_HI:BQ_LO];
    end else if (at_end && !is_cont) begin
      arm_r <= 1'b0;
    end
  end

  // Resume choice is only taken up at a safe point, so a scan never
  // mixes two restart policies
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      resume_eff_r <= 1'b0;
    end else if ((state_r == ST_IDLE) || at_end || mode_chg) begin
      resume_eff_r <= resume_r;
    end
  end

  // Flag events in status bit order
  wire [5:0] flag_set = {I_Q1_DONE, I_Q1_PAUSE, at_end, at_pause, I_Q1_OVERRUN, q2_ovr};
  // Only bits previously read as one may be cleared by writing zero
  wire [5:0] flag_clr = wr_stat && wstrb_r[1] ? (seen_r & ~wdata_r[FL_HI:FL_LO]) : 6'h00;

  // Status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      flag_r <= '0;
      seen_r <= '0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
      if (rd_fire && rd_stat) begin
        seen_r <= (seen_r & ~flag_clr) | flag_r;
      end else begin
        seen_r <= seen_r & ~flag_clr;
      end
    end
  end

  // Sticky interrupt status and mask
  wire [IRQ_W-1:0] ist_set = {q2_ovr, at_pause, at_end};
  wire [IRQ_W-1:0] ist_clr = wr_ist && wstrb_r[0] ? wdata_r[IRQ_W-1:0] : '0;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      ist_r <= '0;
      imask_r <= '0;
    end else begin
      ist_r <= (ist_r & ~ist_clr) | ist_set;
      if (wr_imask && wstrb_r[0]) begin
        imask_r <= wdata_r[IRQ_W-1:0];
      end
    end
  end

  // Queue state code for the status view
  wire [1:0] qs2 = (state_r == ST_PAUSED) ? QS_PAUSED :
                   (state_r == ST_PEND) ? QS_PEND :
                   ((state_r == ST_ACTIVE) || (state_r == ST_SUSP)) ? QS_ACTIVE : QS_IDLE;
  // Pointer shows queue 2 while it owns the converter
  wire [CWP_W-1:0] cwp_view = (state_r == ST_ACTIVE) ? cwp_r : I_Q1_CWP;
  wire [15:0] stat_view = {flag_r, I_Q1_STATE, qs2, cwp_view};
  // Arm bit is masked out of every read
  wire [15:0] mode_view = {done_ie_r, pause_ie_r, 1'b0, mode_r, resume_r, start_r};
  wire [DATA_W-1:0] rd_mux = rd_stat ? {16'h0000, stat_view} :
                             rd_mode ? {16'h0000, mode_view} :
                             rd_ist ? {29'h0, ist_r} :
                             rd_imask ? {29'h0, imask_r} : 32'h00000000;

  // Write channel capture, address and data in either order
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
    end else begin
      if (I_AXI_AWVALID && !aw_full_r) begin
        aw_full_r <= 1'b1;
        awaddr_r <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= I_AXI_WDATA;
        wstrb_r <= I_AXI_WSTRB;
      end
    end
  end

  // Write response; unmapped addresses are answered with an error
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data registered one cycle after the address is taken
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= rd_mux;
    end else if (I_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Bus handshakes
  assign O_AXI_AWREADY = !aw_full_r;
  assign O_AXI_WREADY = !w_full_r;
  assign O_AXI_BVALID = bvalid_r;
  assign O_AXI_BRESP = bresp_r;
  assign O_AXI_ARREADY = !rvalid_r;
  assign O_AXI_RVALID = rvalid_r;
  assign O_AXI_RRESP = rresp_r;
  assign O_AXI_RDATA = rdata_r;

  // Converter and queue 1 side
  assign O_CONV_REQ = (state_r == ST_ACTIVE);
  assign O_CONV_INDEX = cwp_r;
  assign O_Q1_END_INDEX = start_r;
  // Level request follows flags and enables, drops when the flag clears
  assign O_Q2_IRQ_REQ = (flag_r[F_Q2_DONE] & done_ie_r)
                        | (flag_r[F_Q2_PAUSE] & pause_ie_r);
  assign O_IRQ = |(ist_r & imask_r);
endmodule

// file: aqc_q2_ctrl_properties.sv
// Port-level assertions for the queue 2 control block
`timescale 1ns/1ps
module aqc_q2_props
  import aqc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_AXI_BREADY,
  input wire logic I_AXI_RREADY,
  input wire logic I_CONV_DONE,
  input wire logic I_CCW_PAUSE,
  input wire logic I_CCW_EOQ,
  input wire logic I_Q1_ACTIVE,
  input wire logic O_AXI_BVALID,
  input wire logic [1:0] O_AXI_BRESP,
  input wire logic O_AXI_ARREADY,
  input wire logic O_AXI_RVALID,
  input wire logic [DATA_W-1:0] O_AXI_RDATA,
  input wire logic O_CONV_REQ,
  input wire logic [CWP_W-1:0] O_CONV_INDEX,
  input wire logic O_Q2_IRQ_REQ
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  a_bresp_held: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
    else $error("write response dropped early");
  a_bvalid_gap: assert property (O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID)
    else $error("write response repeated");
  a_rdata_held: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
    else $error("read data dropped early");
  a_arready_link: assert property (O_AXI_ARREADY == !O_AXI_RVALID)
    else $error("read address ready wrong");
  a_upper_zero: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_index_step: assert property (O_CONV_REQ && I_CONV_DONE && !I_CCW_PAUSE && !I_CCW_EOQ && !I_Q1_ACTIVE
    && O_CONV_INDEX != 6'h3f |=> O_CONV_INDEX == $past(O_CONV_INDEX) + 6'h01)
    else $error("word index did not advance");
  a_pause_stop: assert property (O_CONV_REQ && I_CONV_DONE && I_CCW_PAUSE && !I_Q1_ACTIVE
    |=> !O_CONV_REQ)
    else $error("queue kept running after pause");
  a_suspend_stop: assert property (O_CONV_REQ && I_Q1_ACTIVE && !I_CONV_DONE |=> !O_CONV_REQ)
    else $error("queue 2 not suspended");
  a_irq_cause: assert property ($rose(O_Q2_IRQ_REQ) |-> $past(I_CONV_DONE) || O_AXI_BVALID)
    else $error("request rose without cause");
endmodule

// file: testbench.sv
// Self-checking bench for the queue 2 control block
`timescale 1ns/1ps
module testbench;
  import aqc_pkg::*;
  logic I_REF_CLK = 0, I_RSTN = 0, I_AXI_AWVALID = 0, I_AXI_WVALID = 0, I_AXI_BREADY = 0;
  logic I_AXI_ARVALID = 0, I_AXI_RREADY = 0, I_CONV_TICK = 0, I_EXT_TRIG = 0;
  logic I_CONV_DONE = 0, I_CCW_PAUSE = 0, I_CCW_EOQ = 0, I_Q1_ACTIVE = 0;
  logic I_Q1_DONE = 0, I_Q1_PAUSE = 0, I_Q1_OVERRUN = 0;
  logic [ADDR_W-1:0] I_AXI_AWADDR = '0, I_AXI_ARADDR = '0;
  logic [DATA_W-1:0] I_AXI_WDATA = '0;
  logic [3:0] I_AXI_WSTRB = '0;
  logic [1:0] I_Q1_STATE = '0;
  logic [CWP_W-1:0] I_Q1_CWP = '0;
  logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
  logic O_CONV_REQ, O_Q2_IRQ_REQ, O_IRQ;
  logic [1:0] O_AXI_BRESP, O_AXI_RRESP;
  logic [DATA_W-1:0] O_AXI_RDATA;
  logic [CWP_W-1:0] O_CONV_INDEX;
  logic [BQ_W-1:0] O_Q1_END_INDEX;
  logic [15:0] d;   // Last read value
  logic [1:0] r;    // Last response code
  int error_cnt = 0, n_checks = 0;
  aqc_q2_ctrl dut_u (.*);
  // 20 MHz clock and a free-running conversion tick
  always #25 I_REF_CLK = ~I_REF_CLK;
  always @(posedge I_REF_CLK) I_CONV_TICK <= ~I_CONV_TICK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  // Handshakes are sampled mid-cycle so the launching edge never races them
  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    logic aw_ok, w_ok, b_ok;
    @(posedge I_REF_CLK);
    I_AXI_AWADDR <= a; I_AXI_WDATA <= {16'h0000, v}; I_AXI_WSTRB <= 4'h3;
    I_AXI_AWVALID <= 1; I_AXI_WVALID <= 1; I_AXI_BREADY <= 1;
    do begin
      @(negedge I_REF_CLK);
      aw_ok = I_AXI_AWVALID && O_AXI_AWREADY;
      w_ok = I_AXI_WVALID && O_AXI_WREADY;
      b_ok = O_AXI_BVALID === 1'b1;
      if (b_ok) r = O_AXI_BRESP;
      @(posedge I_REF_CLK);
      if (aw_ok) I_AXI_AWVALID <= 0;
      if (w_ok) I_AXI_WVALID <= 0;
    end while (!b_ok);
    I_AXI_BREADY <= 0;
  endtask
  // Read: response taken at the edge where rvalid is seen
  task automatic rd(input logic [23:0] a);
    logic ar_ok, r_ok;
    @(posedge I_REF_CLK);
    I_AXI_ARADDR <= a; I_AXI_ARVALID <= 1; I_AXI_RREADY <= 1;
    do begin
      @(negedge I_REF_CLK);
      ar_ok = I_AXI_ARVALID && O_AXI_ARREADY;
      r_ok = O_AXI_RVALID === 1'b1;
      if (r_ok) begin
        d = O_AXI_RDATA[15:0]; r = O_AXI_RRESP;
      end
      @(posedge I_REF_CLK);
      if (ar_ok) I_AXI_ARVALID <= 0;
    end while (!r_ok);
    I_AXI_RREADY <= 0;
  endtask
  // One stored conversion with its pause and end qualifiers
  task automatic conv(input logic p, input logic e);
    @(posedge I_REF_CLK);
    I_CONV_DONE <= 1; I_CCW_PAUSE <= p; I_CCW_EOQ <= e;
    @(posedge I_REF_CLK);
    I_CONV_DONE <= 0; I_CCW_PAUSE <= 0; I_CCW_EOQ <= 0;
    @(posedge I_REF_CLK);
  endtask
  // Bounded wait for the request level; trigger latency is internal
  task automatic wait_req(input logic v);
    for (int i = 0; i < 20 && O_CONV_REQ !== v; i++) @(negedge I_REF_CLK);
    @(posedge I_REF_CLK);
  endtask
  task automatic t_reset;
    rd(STATUS0_ADDR); chk(d, 16'h0000);
    rd(MODE2_ADDR); chk(d, 16'h0000);
    $display("TB: reset values done");
  endtask
  // Arm written with disabled mode: stored fields read back, arm reads zero
  task automatic t_fields;
    wr(MODE2_ADDR, 16'he085); repeat (3) @(posedge I_REF_CLK);
    chk(O_CONV_REQ, 1'b0);
    rd(MODE2_ADDR); chk(d, 16'hc085);
    chk(O_Q1_END_INDEX, 7'h05);
    $display("TB: mode fields done");
  endtask
  task automatic t_scan;
    wr(IRQ_MASK_ADDR, 16'h0007);
    wr(MODE2_ADDR, 16'ha105); wait_req(1);
    chk(O_CONV_REQ, 1'b1);
    chk(O_CONV_INDEX, 6'h05);
    conv(0, 0); chk(O_CONV_INDEX, 6'h06);
    chk(O_Q2_IRQ_REQ, 1'b0);
    conv(0, 1); chk(O_CONV_REQ, 1'b0);
    chk(O_Q2_IRQ_REQ, 1'b1);
    chk(O_IRQ, 1'b1);
    $display("TB: software scan done");
  endtask
  // Clear only after read; read-only fields ignore writes
  task automatic t_clear;
    wr(STATUS0_ADDR, 16'h03ff); rd(STATUS0_ADDR);
    chk(d[15:6], 10'h080);
    wr(STATUS0_ADDR, 16'h0000); rd(STATUS0_ADDR);
    chk(d[15:6], 10'h000);
    chk(O_Q2_IRQ_REQ, 1'b0);
    wr(IRQ_MASK_ADDR, 16'h0000); chk(O_IRQ, 1'b0);
    wr(IRQ_MASK_ADDR, 16'h0007); chk(O_IRQ, 1'b1);
    wr(IRQ_STAT_ADDR, 16'h0001); chk(O_IRQ, 1'b0);
    $display("TB: flag clear done");
  endtask
  // Pause stops the queue and requests with the pause enable
  task automatic t_pause;
    wr(MODE2_ADDR, 16'h6100); wait_req(1);
    conv(1, 0); chk(O_CONV_REQ, 1'b0);
    chk(O_Q2_IRQ_REQ, 1'b1);
    rd(STATUS0_ADDR); chk(d[15:6], 10'h041);
    wr(STATUS0_ADDR, 16'h0000); wr(MODE2_ADDR, 16'h0000);
    chk(O_Q2_IRQ_REQ, 1'b0);
    $display("TB: pause done");
  endtask
  // Rising edge scan, stray edge overrun, suspend by queue 1
  task automatic t_ext;
    wr(MODE2_ADDR, 16'h220a); repeat (3) @(posedge I_REF_CLK);
    rd(STATUS0_ADDR); chk(d[7:6], 2'h3);
    I_EXT_TRIG <= 1; wait_req(1); chk(O_CONV_INDEX, 6'h0a);
    I_EXT_TRIG <= 0; repeat (3) @(posedge I_REF_CLK);
    I_EXT_TRIG <= 1; repeat (3) @(posedge I_REF_CLK);
    I_Q1_ACTIVE <= 1; repeat (3) @(posedge I_REF_CLK);
    chk(O_CONV_REQ, 1'b0);
    I_Q1_ACTIVE <= 0; wait_req(1); conv(0, 1);
    rd(STATUS0_ADDR); chk(d[15:6], 10'h090);
    $display("TB: external trigger done");
  endtask
  // Interval timer scan waits 2^7 ticks; start index 64 idles queue 2
  task automatic t_timer;
    wr(MODE2_ADDR, 16'h2400); repeat (200) @(posedge I_REF_CLK);
    chk(O_CONV_REQ, 1'b0);
    for (int i = 0; i < 100 && O_CONV_REQ !== 1'b1; i++) @(negedge I_REF_CLK);
    chk(O_CONV_REQ, 1'b1);
    wr(MODE2_ADDR, 16'h2140); repeat (3) @(posedge I_REF_CLK);
    chk(O_CONV_REQ, 1'b0);
    chk(O_Q1_END_INDEX, 7'h40);
    $display("TB: timer and start index done");
  endtask
  task automatic t_unmapped;
    wr(24'h304820, 16'hffff); chk(r, RESP_SLVERR);
    rd(24'h304820); chk(r, RESP_SLVERR);
    chk(d, 16'h0000);
    $display("TB: unmapped access done");
  endtask
  task automatic wrap_up;
    $display("TB: checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge I_REF_CLK);
    I_RSTN <= 1;
    @(posedge I_REF_CLK);
    t_reset; t_fields; t_scan; t_clear; t_pause; t_ext; t_timer; t_unmapped;
    wrap_up;
  end
  // Watchdog far beyond the few hundred cycles the tests take
  initial begin
    #1000000;
    error_cnt++;
    wrap_up;
  end
endmodule
bind aqc_q2_ctrl aqc_q2_props props_u (.*);
